// >>> shared/ustc_pkg.sv
package ustc_pkg;
	// register byte addresses on the bus
	localparam logic [3:0] ADDR_SOF_THRESHOLD = 4'h0;
	localparam logic [3:0] ADDR_CONFIG_ONE = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	// field positions
	localparam int EYE_BIT = 7;
	localparam int OEMON_BIT = 6;
	localparam int IDLE_BIT = 4;
	// implemented bit masks of the two writable registers
	localparam logic [15:0] SOF_MASK = 16'h00ff;
	localparam logic [15:0] CFG_MASK = 16'h00d3;
	// reset values
	localparam logic [7:0] SOF_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// threshold overhead in byte times
	localparam logic [7:0] SOF_OVERHEAD = 8'h0a;
	localparam logic [1:0] PPB_EVEN_ODD = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_RESP = 1'b1
	} ustc_bus_e;
endpackage

// >>> rtl/ustc_sof_threshold_config.sv
module ustc_sof_threshold_config
	import ustc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic hostMode,
	input wire logic cpuIdle,
	input wire logic [10:0] bytesToFrame,
	input wire logic tokenRequest,
	input wire logic linesDriving,
	output logic tokenStart,
	output logic eyePatternTestEnable,
	output logic outputEnableIndication,
	output logic moduleHalted,
	output logic evenOddEndpoints
);
	typedef struct packed {
		ustc_bus_e wrState;
		logic awTaken;
		logic wTaken;
		logic [3:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic [1:0] bResp;
		ustc_bus_e rdState;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [7:0] sofThresholdCount;
		logic [7:0] configOne;
		logic tokenStart;
	} ustc_state_s;

	ustc_state_s st;
	ustc_state_s next_st;
	logic wrFire;
	logic eyeTest;
	logic oeMonitor;
	logic haltIdle;
	logic [1:0] ppbConfig;
	logic halted;
	logic tokenAllowed;

	// register read image; unimplemented bits read zero
	function automatic logic [31:0] readImage(input logic [3:0] addr, input ustc_state_s s, input logic hlt);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (addr)
			ADDR_SOF_THRESHOLD: v = {24'h00_0000, s.sofThresholdCount};
			ADDR_CONFIG_ONE: v = {24'h00_0000, s.configOne};
			ADDR_STATUS: v = {30'h0000_0000, s.tokenStart, hlt};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [3:0] addr);
		return addr == ADDR_SOF_THRESHOLD || addr == ADDR_CONFIG_ONE || addr == ADDR_STATUS;
	endfunction

	// configuration fields decoded
	assign eyeTest = st.configOne[EYE_BIT];
	assign oeMonitor = st.configOne[OEMON_BIT];
	assign haltIdle = st.configOne[IDLE_BIT];
	assign ppbConfig = st.configOne[1:0];
	assign halted = haltIdle && cpuIdle;
	// threshold is count bytes: packet plus ten of overhead, host only
	assign tokenAllowed = hostMode && !halted && ({3'h0, st.sofThresholdCount} <= bytesToFrame);
	assign wrFire = (st.awTaken || s_axi_awvalid) && (st.wTaken || s_axi_wvalid) && st.wrState == BUS_IDLE;

	// next state: bus slave plus token gating
	always_comb begin
		next_st = st;
		if (st.wrState == BUS_IDLE) begin
			if (s_axi_awvalid && !st.awTaken) begin
				next_st.awTaken = 1'b1;
				next_st.awAddr = s_axi_awaddr;
			end
			if (s_axi_wvalid && !st.wTaken) begin
				next_st.wTaken = 1'b1;
				next_st.wData = s_axi_wdata;
				next_st.wStrb = s_axi_wstrb;
			end
		end
		if (wrFire) begin
			next_st.awTaken = 1'b0;
			next_st.wTaken = 1'b0;
			next_st.wrState = BUS_RESP;
			next_st.bResp = mapped(next_st.awAddr) ? RESP_OKAY : RESP_SLVERR;
			// only lane 0 holds implemented bits; bits 15-8 are dropped
			if (next_st.wStrb[0] && next_st.awAddr == ADDR_SOF_THRESHOLD) begin
				next_st.sofThresholdCount = next_st.wData[7:0] & SOF_MASK[7:0];
			end
			if (next_st.wStrb[0] && next_st.awAddr == ADDR_CONFIG_ONE) begin
				next_st.configOne = next_st.wData[7:0] & CFG_MASK[7:0];
			end
		end else if (st.wrState == BUS_RESP && s_axi_bready) begin
			next_st.wrState = BUS_IDLE;
		end
		case (st.rdState)
			BUS_IDLE: begin
				if (s_axi_arvalid) begin
					next_st.rdState = BUS_RESP;
					next_st.rData = readImage(s_axi_araddr, st, halted);
					next_st.rResp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				end
			end
			BUS_RESP: begin
				if (s_axi_rready) begin
					next_st.rdState = BUS_IDLE;
				end
			end
			default: next_st.rdState = BUS_IDLE;
		endcase
		// token start follows the request one cycle later, refused when too little frame is left
		next_st.tokenStart = tokenRequest && tokenAllowed;
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{wrState: BUS_IDLE, rdState: BUS_IDLE, sofThresholdCount: SOF_RESET,
				configOne: CFG_RESET, bResp: RESP_OKAY, rResp: RESP_OKAY, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// bus handshake outputs
	assign s_axi_awready = st.wrState == BUS_IDLE && !st.awTaken;
	assign s_axi_wready = st.wrState == BUS_IDLE && !st.wTaken;
	assign s_axi_bvalid = st.wrState == BUS_RESP;
	assign s_axi_bresp = st.bResp;
	assign s_axi_arready = st.rdState == BUS_IDLE;
	assign s_axi_rvalid = st.rdState == BUS_RESP;
	assign s_axi_rdata = st.rData;
	assign s_axi_rresp = st.rResp;
	// controls to the rest of the controller
	assign tokenStart = st.tokenStart;
	assign eyePatternTestEnable = eyeTest;
	assign outputEnableIndication = oeMonitor && linesDriving;
	assign moduleHalted = halted;
	assign evenOddEndpoints = ppbConfig == PPB_EVEN_ODD;

	// the encoding examples, checked on stored counts
	localparam logic [7:0] PKT64_COUNT = 8'h4a;
	localparam logic [7:0] PKT8_COUNT = 8'h12;

	sequence countIs64;
		st.sofThresholdCount == PKT64_COUNT;
	endsequence

	host_only_a: assert property (@(posedge clk) disable iff (!rst_n)
		!hostMode |=> !tokenStart) else $error("token started outside host mode");
	upper_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper threshold bits not zero");
	encoding_a: assert property (@(posedge clk) disable iff (!rst_n)
		tokenStart |-> $past(bytesToFrame) >= {3'h0, $past(st.sofThresholdCount)})
		else $error("token started below threshold");
	// a 64-byte count needs 74 byte times, so exactly 74 left must still be enough
	pkt64_a: assert property (@(posedge clk) disable iff (!rst_n)
		countIs64 and (hostMode && !halted && bytesToFrame == 11'h04a) |-> tokenAllowed)
		else $error("64-byte count refuses token");
	pkt8_a: assert property (@(posedge clk) disable iff (!rst_n)
		st.sofThresholdCount == PKT8_COUNT && bytesToFrame == 11'd17 |-> !tokenAllowed)
		else $error("8-byte count allows short frame");
	eye_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
		eyePatternTestEnable == st.configOne[7]) else $error("eye test not bit 7");
	oe_monitor_a: assert property (@(posedge clk) disable iff (!rst_n)
		outputEnableIndication |-> linesDriving && st.configOne[6]) else $error("oe indication wrong");
	idle_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
		st.configOne[4] && cpuIdle |=> !tokenStart) else $error("token while halted in idle");
	ping_pong_a: assert property (@(posedge clk) disable iff (!rst_n)
		evenOddEndpoints == (st.configOne[1:0] == 2'h3)) else $error("ping-pong decode wrong");
	token_window_a: assert property (@(posedge clk) disable iff (!rst_n)
		tokenRequest && hostMode && bytesToFrame < {3'h0, st.sofThresholdCount} |=> !tokenStart)
		else $error("token started too close to frame");

	// bus answers come one cycle after acceptance; refused addresses answer with an error
	sequence writeAccepted;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	sequence readAccepted;
		s_axi_arvalid && s_axi_arready;
	endsequence

	write_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
		writeAccepted |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready) else $error("write not answered");
	read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
		readAccepted |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
	unmapped_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		writeAccepted ##0 !mapped(s_axi_awaddr) |=> s_axi_bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	idle_continue_a: assert property (@(posedge clk) disable iff (!rst_n)
		!st.configOne[IDLE_BIT] |-> !moduleHalted) else $error("halted with stop-in-idle clear");
endmodule // ustc_sof_threshold_config

// >>> tb/ustc_usb_far_side.sv
module ustc_usb_far_side
	import ustc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	output logic [10:0] bytesToFrame,
	output logic linesDriving
);
	timeunit 1ns;
	timeprecision 1ns;
	// byte times count down to the next frame, then reload as a new frame starts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) bytesToFrame <= 11'h060;
		else bytesToFrame <= (bytesToFrame == 11'h000) ? 11'h060 : bytesToFrame - 11'h001;
	end
	assign linesDriving = bytesToFrame[1]; // bursts of two cycles, so a stuck indication shows
endmodule // ustc_usb_far_side

// >>> tb/test_usb_sof_threshold_config.sv
module test_usb_sof_threshold_config
	import ustc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hostMode = 1'b0, cpuIdle = 1'b0, tokenRequest = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [10:0] bytesToFrame;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, linesDriving, tokenStart;
	logic eyePatternTestEnable, outputEnableIndication, moduleHalted, evenOddEndpoints, e;
	int error_cnt = 0, check_count = 0;
	ustc_sof_threshold_config dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hostMode,
		.cpuIdle, .bytesToFrame, .tokenRequest, .linesDriving, .tokenStart, .eyePatternTestEnable,
		.outputEnableIndication, .moduleHalted, .evenOddEndpoints);
	ustc_usb_far_side far (.clk, .rst_n, .bytesToFrame, .linesDriving);
	// free running clock; settle time is half a period so checks sit at the falling edge
	initial begin
		forever #10 clk = ~clk;
	end
	task chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, x);
		end
	endtask
	// handshakes are judged at the falling edge, where nothing moves, and released at the rising edge
	task wr(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, dn;
		dn = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
		// no cycle count assumed: only the watchdog ends a wait for the answer
		while (!dn) begin
			@(negedge clk);
			ta = s_axi_awready; tw = s_axi_wready; dn = s_axi_bvalid; rs = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (dn) s_axi_bready <= 1'b0;
		end
	endtask
	task rdr(input logic [3:0] a);
		logic ta, dn;
		dn = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		while (!dn) begin
			@(negedge clk);
			ta = s_axi_arready; dn = s_axi_rvalid; rd = s_axi_rdata; rs = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (dn) s_axi_rready <= 1'b0;
		end
	endtask
	// threshold keeps only its count byte; both coded packet sizes survive
	task t_sof;
		rdr(ADDR_SOF_THRESHOLD); chk(rd, 32'h0);
		wr(ADDR_SOF_THRESHOLD, 32'hffff_ff4a); rdr(ADDR_SOF_THRESHOLD); chk(rd, 32'd64 + 32'd10);
		wr(ADDR_SOF_THRESHOLD, 32'h0000_ab12); rdr(ADDR_SOF_THRESHOLD); chk(rd, 32'd8 + 32'd10);
	endtask
	// all config bits set: reserved ones read zero, eye test and even/odd bits reach their outputs
	task t_cfg;
		wr(ADDR_CONFIG_ONE, 32'h0000_00ff); rdr(ADDR_CONFIG_ONE); chk(rd, 32'h0000_00d3);
		chk(eyePatternTestEnable, 1'b1);
		chk(evenOddEndpoints, 1'b1);
		// stop-in-idle now set: an idle processor halts the block, seen in status bit 0
		cpuIdle <= 1'b1;
		rdr(ADDR_STATUS);
		chk(rd, 32'h0000_0001);
		chk(moduleHalted, 1'b1);
		cpuIdle <= 1'b0;
		wr(4'hc, 32'h0000_00ff); chk(rs, RESP_SLVERR);
		rdr(4'hc); chk(rs, RESP_SLVERR);
	endtask
	// token grants against host mode, idle halt and bytes left, for one packet size
	task t_tok(input logic [7:0] pkt);
		logic [10:0] need;
		need = {3'h0, SOF_OVERHEAD} + {3'h0, pkt};
		wr(ADDR_SOF_THRESHOLD, {21'h00_0000, need});
		chk(rs, RESP_OKAY);
		for (int i = 0; i < 70; i++) begin
			@(posedge clk);
			hostMode <= (i % 7) != 0; cpuIdle <= (i % 5) == 0; tokenRequest <= 1'b1;
			@(negedge clk);
			e = hostMode && !cpuIdle && (need <= bytesToFrame);
			chk(outputEnableIndication, linesDriving);
			chk(moduleHalted, cpuIdle);
			@(negedge clk);
			chk(tokenStart, e);
		end
	endtask
	// configuration cleared: eye test, output enable and even/odd controls drop and an idle processor no longer halts
	task t_off;
		wr(ADDR_CONFIG_ONE, 32'h0);
		cpuIdle <= 1'b1;
		@(negedge clk);
		chk(eyePatternTestEnable, 1'b0);
		chk(outputEnableIndication, 1'b0);
		chk(evenOddEndpoints, 1'b0);
		chk(moduleHalted, 1'b0);
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_sof;
		t_cfg;
		t_tok(8'h08);
		t_tok(8'h40);
		t_off;
		tally_and_finish;
	end
endmodule // test_usb_sof_threshold_config
